// [core/dsau_pkg.sv]
// data-space access unit: shared constants, enumerations and carrier structs
// assumes one core clock; all widths are fixed by the 16-bit data path
package dsau_pkg;

   localparam int EA_W    = 16;               // effective byte address width
   localparam int PAGE_W  = 8;                // page value width, 8 + 16 = 24 bits = 16 Mbytes
   localparam int XA_W    = PAGE_W + EA_W;    // extended address width
   localparam int WORD_W  = 16;
   localparam int BYTE_W  = 8;
   localparam int LANES   = 2;                // two byte-wide halves per word
   localparam int NEAR_W  = 13;               // absolute field of memory-direct forms
   localparam int REV_W   = 4;                // 16-entry bit-reversed index
   localparam int REV_LSB = 1;                // index sits above the byte-select bit

   localparam int RAM_BYTES_MAX = 49152;      // 48 Kbytes of RAM at most

   localparam logic [EA_W-1:0]   SFR_LAST  = 16'h0fff;
   localparam logic [EA_W-1:0]   RAM_BASE  = 16'h1000;
   localparam logic [EA_W-1:0]   NEAR_LAST = 16'h1fff;
   localparam logic [EA_W-1:0]   STEP_BYTE = 16'h0001;
   localparam logic [EA_W-1:0]   STEP_WORD = 16'h0002;
   localparam logic [PAGE_W-1:0] HOME_PAGE = 8'h00;
   localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;
   localparam logic [WORD_W-1:0] ZERO_WORD = 16'h0000;
   localparam logic [LANES-1:0]  LANE_LO   = 2'h1;
   localparam logic [LANES-1:0]  LANE_HI   = 2'h2;
   localparam logic [LANES-1:0]  LANE_BOTH = 2'h3;
   localparam logic [LANES-1:0]  LANE_NONE = 2'h0;

   // how the base address is formed (gray along the usual order)
   typedef enum logic [1:0]
   {
      MODE_INDIRECT = 2'h0,
      MODE_DIRECT16 = 2'h1,
      MODE_NEAR13   = 2'h3
   } addrMode_t;

   // pointer update applied after the access
   typedef enum logic [1:0]
   {
      MOD_NONE   = 2'h0,
      MOD_INC    = 2'h1,
      MOD_DEC    = 2'h3,
      MOD_BITREV = 2'h2
   } postMod_t;

   typedef enum logic [1:0]
   {
      EXT_NONE = 2'h0,
      EXT_SIGN = 2'h1,
      EXT_ZERO = 2'h3
   } extOp_t;

   // one access request from an address generator
   typedef struct packed
   {
      logic [PAGE_W-1:0] page;
      logic [EA_W-1:0]   addr;
      addrMode_t         mode;
      logic              isByte;
      postMod_t          postMod;
   } accessReq_t;

   // registered answer to a read
   typedef struct packed
   {
      logic              valid;
      logic [WORD_W-1:0] data;
      logic [WORD_W-1:0] wregNew;
      logic [EA_W-1:0]   ptrNext;
      logic [XA_W-1:0]   xAddr;
   } readResp_t;

   // registered answer to a write
   typedef struct packed
   {
      logic              done;
      logic              suppressed;
      logic [EA_W-1:0]   ptrNext;
      logic [XA_W-1:0]   xAddr;
   } writeResp_t;

   // all state of the access unit apart from the RAM storage
   typedef struct packed
   {
      readResp_t         rd;
      writeResp_t        wr;
      logic [LANES-1:0]  sfrWrLanes;
      logic [EA_W-1:0]   sfrWrAddr;
      logic [WORD_W-1:0] sfrWrData;
      logic              extValid;
      logic [WORD_W-1:0] extResult;
      logic              address_error_flag;
      logic              addrErrWr;
   } unitState_t;

endpackage

// [core/dual_lane_ram.sv]
// two parallel byte-wide storage halves with one word index and own write lanes
// assumes the caller has already decoded the RAM region and formed word indexes
`timescale 1ns/1ps
`default_nettype none
module dual_lane_ram
   import dsau_pkg::*;
#(
   parameter int WORDS = RAM_BYTES_MAX / 2,
   parameter int IDX_W = $clog2(WORDS)
)
(
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   input  wire logic [LANES-1:0]       wrLane,
   input  wire logic [IDX_W-1:0]       wrIdx,
   input  wire logic [WORD_W-1:0]      wrData,
   input  wire logic [IDX_W-1:0]       rdIdx,
   output logic      [WORD_W-1:0]      rdWord
);

   typedef struct packed
   {
      logic [WORDS-1:0][LANES-1:0][BYTE_W-1:0] mem;
   } ramState_t;

   ramState_t state_r;
   ramState_t state_nxt;

   // two words at least, and an index wide enough to reach them all
   if (WORDS < 2 || IDX_W < $clog2(WORDS))
   begin : gBadSize
      $error("dual_lane_ram: bad size");
   end

   // each half owns its write line; the word index is shared
   always_comb
   begin
      state_nxt = state_r;
      for (int l = 0; l < LANES; l++)
      begin
         if (wrLane[l] && int'(wrIdx) < WORDS)
            state_nxt.mem[wrIdx][l] = wrData[l*BYTE_W +: BYTE_W];
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         state_r <= '0;
      else
         state_r <= state_nxt;
   end

   // read sees the stored word, not a write landing on the same edge
   genvar g;
   generate
      for (g = 0; g < LANES; g++)
      begin : gLane
         assign rdWord[g*BYTE_W +: BYTE_W] =
            (int'(rdIdx) < WORDS) ? state_r.mem[rdIdx][g] : ZERO_BYTE;
      end
   endgenerate

endmodule
`default_nettype wire

// [core/data_space_access_unit.sv]
// data-space access unit: read/write address paths, region decode,
// byte lanes, address error trap request, extension ops, bit reversal
// assumes the core pipeline drives requests on clk and the peripheral
// register file answers reads in the same cycle (sfrRdHit, sfrRdData)
// all inputs come from logic on clk, so none is synchronised
// only page zero maps implemented memory; other pages read zero
`timescale 1ns/1ps
`default_nettype none
module data_space_access_unit
   import dsau_pkg::*;
#(
   parameter int RAM_BYTES = RAM_BYTES_MAX
)
(
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   input  wire logic                  rdEn,
   input  wire accessReq_t            rdReq,
   input  wire logic [WORD_W-1:0]     wregOld,
   input  wire logic                  wrEn,
   input  wire accessReq_t            wrReq,
   input  wire logic [WORD_W-1:0]     wrData,
   input  wire logic                  extEn,
   input  wire extOp_t                extOp,
   input  wire logic [WORD_W-1:0]     extSrc,
   input  wire logic                  sfrRdHit,
   input  wire logic [WORD_W-1:0]     sfrRdData,
   output logic                       sfrRdEn,
   output logic      [EA_W-1:0]       sfrRdAddr,
   output logic      [LANES-1:0]      sfrWrLanes,
   output logic      [EA_W-1:0]       sfrWrAddr,
   output logic      [WORD_W-1:0]     sfrWrData,
   output readResp_t                  rdResp,
   output writeResp_t                 wrResp,
   output logic                       extValid,
   output logic      [WORD_W-1:0]     extResult,
   output logic                       addrErrReq,
   output logic                       addrErrIsWrite
);

   // storage size behind the register region
   localparam int RAM_WORDS = RAM_BYTES / 2;
   localparam int IDX_W     = $clog2(RAM_WORDS);

   // the RAM sits above the register region and may not exceed 48 Kbytes;
   // two words at least, or the RAM index would have no bits
   if (RAM_BYTES < 2 * LANES || RAM_BYTES > RAM_BYTES_MAX || (RAM_BYTES % 2) != 0)
   begin : gBadSize
      $error("data_space_access_unit: RAM_BYTES out of range");
   end

   // all unit state apart from the RAM storage lives in one struct
   unitState_t state_r;
   unitState_t state_nxt;

   // all decode is from this cycle's request
   // decoded read path
   logic [EA_W-1:0]   rdEa;
   logic              rdSfr;
   logic              rdRam;
   logic              rdMis;
   logic [IDX_W-1:0]  rdIdx;
   logic [WORD_W-1:0] ramWord;
   logic [WORD_W-1:0] rdWord;
   logic [BYTE_W-1:0] rdLane;

   // decoded write path
   logic [EA_W-1:0]   wrEa;
   logic              wrSfr;
   logic              wrRam;
   logic              wrMis;
   logic [IDX_W-1:0]  wrIdx;
   logic [LANES-1:0]  wrLanes;
   logic [LANES-1:0]  ramLanes;

   // decode helpers, shared by both address generators

   // base address from the addressing form of the request
   // near forms zero the top bits: they stay in the low 8 Kbytes;
   // direct and indirect forms pass the full address
   function automatic logic [EA_W-1:0] formEa(input accessReq_t req);
      logic [EA_W-1:0] ea;
      ea = req.addr;
      case (req.mode)
         MODE_NEAR13:   ea = {{(EA_W-NEAR_W){1'b0}}, req.addr[NEAR_W-1:0]};
         MODE_DIRECT16: ea = req.addr;
         MODE_INDIRECT: ea = req.addr;
         default:       ea = req.addr;
      endcase
      return ea;
   endfunction

   // register region: page zero, low 4 Kbytes
   // holes inside are the register file's concern
   function automatic logic inSfr(input logic [PAGE_W-1:0] pg, input logic [EA_W-1:0] ea);
      return (pg == HOME_PAGE) && (ea <= SFR_LAST);
   endfunction

   // RAM region: page zero, starting right above the registers
   // bound one bit wider so a full-size RAM cannot wrap
   function automatic logic inRam(input logic [PAGE_W-1:0] pg, input logic [EA_W-1:0] ea);
      logic [EA_W:0] top;
      top = {1'b0, RAM_BASE} + (EA_W+1)'(RAM_BYTES);
      return (pg == HOME_PAGE) && (ea >= RAM_BASE) && ({1'b0, ea} < top);
   endfunction

   // word index inside the RAM; byte bit dropped, shared by both halves
   // with no byte bit a misaligned word read gets the
   // aligned word holding the addressed byte
   function automatic logic [IDX_W-1:0] ramIndex(input logic [EA_W-1:0] ea);
      logic [EA_W-1:0] off;
      off = ea - RAM_BASE;
      return IDX_W'(off[EA_W-1:1]);
   endfunction

   // reverse the index bits; pure rewiring, no logic
   function automatic logic [REV_W-1:0] revBits(input logic [REV_W-1:0] v);
      logic [REV_W-1:0] r;
      r = '0;
      for (int i = 0; i < REV_W; i++)
      begin
         r[i] = v[REV_W-1-i];
      end
      return r;
   endfunction

   // pointer after the access; steps scale with access size
   // steps use the raw address field, not the near-form EA;
   // decrement wraps below zero like a plain adder
   function automatic logic [EA_W-1:0] nextPtr(input accessReq_t req);
      logic [EA_W-1:0]  step;
      logic [EA_W-1:0]  p;
      logic [REV_W-1:0] idx;
      step = req.isByte ? STEP_BYTE : STEP_WORD;
      p    = req.addr;
      idx  = req.addr[REV_LSB +: REV_W];
      case (req.postMod)
         MOD_INC:    p = req.addr + step;
         MOD_DEC:    p = req.addr - step;
         // walk the table in order: reversed index of the next entry
         // reverse, step, reverse back: 0, 8, 4, 12, 2, ...
         // entry 15 wraps to entry 0 on its own
         MOD_BITREV: p[REV_LSB +: REV_W] = revBits(revBits(idx) + 4'h1);
         MOD_NONE:   p = req.addr;
         default:    p = req.addr;
      endcase
      return p;
   endfunction

   // read address generator
   // byte accesses may use any address
   // only a real read can fault
   assign rdEa  = formEa(rdReq);
   assign rdSfr = inSfr(rdReq.page, rdEa);
   assign rdRam = inRam(rdReq.page, rdEa);
   assign rdMis = rdEn && !rdReq.isByte && rdEa[0];
   assign rdIdx = ramIndex(rdEa);

   // write address generator, fully separate from the read side
   // a store may share a cycle with a read
   assign wrEa  = formEa(wrReq);
   assign wrSfr = inSfr(wrReq.page, wrEa);
   assign wrRam = inRam(wrReq.page, wrEa);
   assign wrMis = wrEn && !wrReq.isByte && wrEa[0];
   assign wrIdx = ramIndex(wrEa);

   // write lanes: even address is the low half, odd the high half
   // a dropped store still reports done, so the
   // instruction retires before the trap
   always_comb
   begin
      if (!wrEn || wrMis)
      begin
         wrLanes = LANE_NONE;
      end
      else if (!wrReq.isByte)
      begin
         wrLanes = LANE_BOTH;
      end
      else if (wrEa[0])
      begin
         wrLanes = LANE_HI;
      end
      else
      begin
         wrLanes = LANE_LO;
      end
   end

   // writes outside implemented memory simply vanish
   // without this gate a far store would alias into the RAM
   assign ramLanes = wrRam ? wrLanes : LANE_NONE;

   // read port is combinational; writes land at the edge
   dual_lane_ram
   #(
      .WORDS (RAM_WORDS),
      .IDX_W (IDX_W)
   )
   uRam
   (
      .clk    (clk),
      .arst_n (arst_n),
      .wrLane (ramLanes),
      .wrIdx  (wrIdx),
      .wrData (wrData),
      .rdIdx  (rdIdx),
      .rdWord (ramWord)
   );

   // register region read strobe; a misaligned word still reads its word
   // the register file must answer before the edge
   assign sfrRdEn   = rdEn && rdSfr;
   assign sfrRdAddr = {rdEa[EA_W-1:1], 1'b0};

   // word source: registers, RAM, or zero for anything unimplemented
   // trade-off: same-cycle register answers keep one-cycle
   // read latency but lengthen the read data path
   always_comb
   begin
      if (rdSfr)
      begin
         rdWord = sfrRdHit ? sfrRdData : ZERO_WORD;
      end
      else if (rdRam)
      begin
         rdWord = ramWord;
      end
      else
      begin
         rdWord = ZERO_WORD;
      end
   end

   // byte select by the low address bit
   // word accesses take the whole word instead
   assign rdLane = rdEa[0] ? rdWord[WORD_W-1:BYTE_W] : rdWord[BYTE_W-1:0];

   // next state of every register in the unit apart from the RAM storage
   always_comb
   begin
      // every field keeps its value unless changed below
      state_nxt = state_r;

      // read answer: data lands one edge after the request
      // fields other than valid hold until the next read
      state_nxt.rd.valid = rdEn;
      if (rdEn)
      begin
         state_nxt.rd.data    = rdReq.isByte ? {ZERO_BYTE, rdLane} : rdWord;
         // byte loads merge into the old register value
         state_nxt.rd.wregNew = rdReq.isByte ? {wregOld[WORD_W-1:BYTE_W], rdLane} : rdWord;
         state_nxt.rd.ptrNext = nextPtr(rdReq);
         state_nxt.rd.xAddr   = {rdReq.page, rdEa};
      end

      // write answer: the instruction completes even when the store is dropped
      // suppressed tells the core the store never landed
      // every enabled store, dropped or not, moves pointer and address
      state_nxt.wr.done       = wrEn;
      state_nxt.wr.suppressed = wrMis;
      if (wrEn)
      begin
         state_nxt.wr.ptrNext = nextPtr(wrReq);
         state_nxt.wr.xAddr   = {wrReq.page, wrEa};
      end

      // register-region stores leave through registered lanes
      // address and data hold until the next region store
      state_nxt.sfrWrLanes = wrSfr ? wrLanes : LANE_NONE;
      if (wrEn && wrSfr)
      begin
         state_nxt.sfrWrAddr = {wrEa[EA_W-1:1], 1'b0};
         state_nxt.sfrWrData = wrData;
      end

      // extension ops on a working register value
      // no valid for EXT_NONE, which keeps the result
      // the result holds until the next extension op
      state_nxt.extValid = extEn && (extOp != EXT_NONE);
      if (extEn)
      begin
         case (extOp)
            EXT_SIGN: state_nxt.extResult = {{BYTE_W{extSrc[BYTE_W-1]}}, extSrc[BYTE_W-1:0]};
            EXT_ZERO: state_nxt.extResult = {ZERO_BYTE, extSrc[BYTE_W-1:0]};
            EXT_NONE: state_nxt.extResult = state_r.extResult;
            default:  state_nxt.extResult = state_r.extResult;
         endcase
      end

      // trap request follows the access by one edge, for one cycle
      // a read and a write faulting together flag a write
      // rebuilt every cycle, so no set/clear race exists
      state_nxt.address_error_flag   = rdMis || wrMis;
      state_nxt.addrErrWr = wrMis;
   end

   // one register stage for the whole unit
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // everything the core sees comes straight from flip-flops
   // the exception logic must latch the one-cycle trap pulse
   assign rdResp         = state_r.rd;
   assign wrResp         = state_r.wr;
   assign sfrWrLanes     = state_r.sfrWrLanes;
   assign sfrWrAddr      = state_r.sfrWrAddr;
   assign sfrWrData      = state_r.sfrWrData;
   assign extValid       = state_r.extValid;
   assign extResult      = state_r.extResult;
   assign addrErrReq     = state_r.address_error_flag;
   assign addrErrIsWrite = state_r.addrErrWr;

endmodule
`default_nettype wire

// [verification/data_space_access_unit_chk.sv]
// checker for the access unit: timing and value relations at its ports
// assumes one clock clk and the asynchronous active-low reset arst_n
`timescale 1ns/1ps
`default_nettype none
module data_space_access_unit_chk
   import dsau_pkg::*;
(
   input wire logic              clk,
   input wire logic              arst_n,
   input wire logic              rdEn,
   input wire accessReq_t        rdReq,
   input wire logic              wrEn,
   input wire accessReq_t        wrReq,
   input wire logic              extEn,
   input wire extOp_t            extOp,
   input wire logic [WORD_W-1:0] extSrc,
   input wire logic              sfrRdEn,
   input wire logic [EA_W-1:0]   sfrRdAddr,
   input wire logic [LANES-1:0]  sfrWrLanes,
   input wire readResp_t         rdResp,
   input wire writeResp_t        wrResp,
   input wire logic              extValid,
   input wire logic [WORD_W-1:0] extResult,
   input wire logic              addrErrReq,
   input wire logic              addrErrIsWrite
);
   logic [EA_W-1:0]   rEa;
   logic [EA_W-1:0]   wEa;
   logic [XA_W-1:0]   rXa;
   logic              rBad;
   logic              wBad;
   logic              wSfr;
   logic [LANES-1:0]  wLane;
   logic [WORD_W-1:0] sgnExp;
   // near-13 forms drop the top three address bits
   assign rEa = (rdReq.mode == MODE_NEAR13) ? {3'h0, rdReq.addr[12:0]} : rdReq.addr;
   assign wEa = (wrReq.mode == MODE_NEAR13) ? {3'h0, wrReq.addr[12:0]} : wrReq.addr;
   assign rXa = {rdReq.page, rEa};
   assign rBad = rdEn && !rdReq.isByte && rdReq.addr[0];
   assign wBad = wrEn && !wrReq.isByte && wrReq.addr[0];
   assign wSfr = wrEn && !wBad && wrReq.page == HOME_PAGE && wEa <= SFR_LAST;
   assign wLane = wrReq.isByte ? (wrReq.addr[0] ? LANE_HI : LANE_LO) : LANE_BOTH;
   assign sgnExp = {{8{extSrc[7]}}, extSrc[7:0]};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // a faulting write shows the trap, the suppression and no lane strobe together
   sequence s_wrFault;
      addrErrReq && addrErrIsWrite && wrResp.suppressed && sfrWrLanes == LANE_NONE;
   endsequence
   property p_rd; rdEn |=> rdResp.valid; endproperty
   property p_wr; wrEn && !wBad |=> wrResp.done; endproperty
   property p_xaddr; rdEn |=> rdResp.xAddr == $past(rXa); endproperty
   property p_sfrRd; sfrRdEn == (rdEn && rdReq.page == HOME_PAGE && rEa <= SFR_LAST); endproperty
   property p_sfrAddr; sfrRdEn |-> sfrRdAddr == {rEa[15:1], 1'b0}; endproperty
   property p_lane; wSfr |=> sfrWrLanes == $past(wLane); endproperty
   property p_trapWr; wBad |=> s_wrFault; endproperty
   property p_trapRd; rBad && !wBad |=> addrErrReq && !addrErrIsWrite; endproperty
   property p_noerr; !rBad && !wBad |=> !addrErrReq; endproperty
   property p_ext; extEn && extOp == EXT_SIGN |=> extValid && extResult == $past(sgnExp); endproperty
   a_rd: assert property (p_rd) else $error("read answer missing");
   a_wr: assert property (p_wr) else $error("write answer missing");
   a_xaddr: assert property (p_xaddr) else $error("extended address wrong");
   a_sfrRd: assert property (p_sfrRd) else $error("register region decode wrong");
   a_sfrAddr: assert property (p_sfrAddr) else $error("register read address wrong");
   a_lane: assert property (p_lane) else $error("write lanes wrong");
   a_trapWr: assert property (p_trapWr) else $error("faulting write not suppressed");
   a_trapRd: assert property (p_trapRd) else $error("read trap missing");
   a_noerr: assert property (p_noerr) else $error("spurious trap");
   a_ext: assert property (p_ext) else $error("sign extension wrong");
endmodule
bind data_space_access_unit data_space_access_unit_chk data_space_access_unit_chk_i
(
   .clk(clk), .arst_n(arst_n), .rdEn(rdEn), .rdReq(rdReq), .wrEn(wrEn), .wrReq(wrReq),
   .extEn(extEn), .extOp(extOp), .extSrc(extSrc), .sfrRdEn(sfrRdEn), .sfrRdAddr(sfrRdAddr),
   .sfrWrLanes(sfrWrLanes), .rdResp(rdResp), .wrResp(wrResp), .extValid(extValid),
   .extResult(extResult), .addrErrReq(addrErrReq), .addrErrIsWrite(addrErrIsWrite)
);
`default_nettype wire

// [verification/sfr_model.sv]
// register-region partner: one implemented word, holes elsewhere
// assumes the access unit's register-side ports on the same clock
`timescale 1ns/1ps
`default_nettype none
module sfr_model
   import dsau_pkg::*;
#(
   parameter logic [EA_W-1:0] REG_ADDR = 16'h0240
)
(
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              sfrRdEn,
   input  wire logic [EA_W-1:0]   sfrRdAddr,
   input  wire logic [LANES-1:0]  sfrWrLanes,
   input  wire logic [EA_W-1:0]   sfrWrAddr,
   input  wire logic [WORD_W-1:0] sfrWrData,
   output logic                   sfrRdHit,
   output logic      [WORD_W-1:0] sfrRdData
);
   logic [WORD_W-1:0] held_r;
   // only one word answers, so every other region address is a hole
   assign sfrRdHit = sfrRdEn && sfrRdAddr == REG_ADDR;
   // unselected lines carry the inverse so a stale word cannot pass for data
   assign sfrRdData = sfrRdHit ? held_r : ~held_r;
   // each byte half has its own strobe
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         held_r <= ZERO_WORD;
      else if (sfrWrAddr == REG_ADDR)
      begin
         if (sfrWrLanes[0])
            held_r[7:0] <= sfrWrData[7:0];
         if (sfrWrLanes[1])
            held_r[15:8] <= sfrWrData[15:8];
      end
   end
endmodule
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the access unit with a small RAM
// assumes the unit, its package and the register-region model
`timescale 1ns/1ps
`default_nettype none
module testbench
   import dsau_pkg::*;
;
   logic              clk = 1'b0;
   logic              arst_n = 1'b0;
   logic              rdEn = 1'b0, wrEn = 1'b0, extEn = 1'b0;
   accessReq_t        rdReq = '0, wrReq = '0;
   logic [WORD_W-1:0] wregOld = '0, wrData = '0, extSrc = '0;
   extOp_t            extOp = EXT_NONE;
   logic              sfrRdEn, sfrRdHit, extValid, addrErrReq, addrErrIsWrite;
   logic [EA_W-1:0]   sfrRdAddr, sfrWrAddr;
   logic [WORD_W-1:0] sfrRdData, sfrWrData, extResult;
   logic [LANES-1:0]  sfrWrLanes;
   readResp_t         rdResp;
   writeResp_t        wrResp;
   int                bad_count = 0, cmp_count = 0;
   // 64 bytes of RAM: region 0x1000..0x103f
   data_space_access_unit #(.RAM_BYTES(64)) data_space_access_unit_i
   (
      .clk(clk), .arst_n(arst_n), .rdEn(rdEn), .rdReq(rdReq), .wregOld(wregOld), .wrEn(wrEn),
      .wrReq(wrReq), .wrData(wrData), .extEn(extEn), .extOp(extOp), .extSrc(extSrc),
      .sfrRdHit(sfrRdHit), .sfrRdData(sfrRdData), .sfrRdEn(sfrRdEn), .sfrRdAddr(sfrRdAddr),
      .sfrWrLanes(sfrWrLanes), .sfrWrAddr(sfrWrAddr), .sfrWrData(sfrWrData), .rdResp(rdResp),
      .wrResp(wrResp), .extValid(extValid), .extResult(extResult), .addrErrReq(addrErrReq),
      .addrErrIsWrite(addrErrIsWrite)
   );
   sfr_model sfr_model_i
   (
      .clk(clk), .arst_n(arst_n), .sfrRdEn(sfrRdEn), .sfrRdAddr(sfrRdAddr), .sfrWrLanes(sfrWrLanes),
      .sfrWrAddr(sfrWrAddr), .sfrWrData(sfrWrData), .sfrRdHit(sfrRdHit), .sfrRdData(sfrRdData)
   );
   always #20 clk = ~clk;
   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
      cmp_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   function automatic accessReq_t rq(input logic [15:0] a, input logic b, input postMod_t m,
                                     input addrMode_t d = MODE_INDIRECT, input logic [7:0] p = 8'h00);
      return '{p, a, d, b, m};
   endfunction
   function automatic logic [3:0] rev4(input logic [3:0] v);
      return {v[0], v[1], v[2], v[3]};
   endfunction
   // requests rise at a falling edge and drop one cycle later; answers are settled then
   task automatic rd(input accessReq_t q, input logic [15:0] old = 16'h0000);
      @(negedge clk);
      rdEn = 1'b1;
      rdReq = q;
      wregOld = old;
      @(negedge clk);
      rdEn = 1'b0;
   endtask
   task automatic wr(input accessReq_t q, input logic [15:0] d);
      @(negedge clk);
      wrEn = 1'b1;
      wrReq = q;
      wrData = d;
      @(negedge clk);
      wrEn = 1'b0;
   endtask
   task automatic t_word();
      wr(rq(16'h1000, 1'b0, MOD_INC), 16'ha55a);
      chk("wr done", 1'b1, wrResp.done);
      chk("wr ptr", 16'h1002, wrResp.ptrNext);
      rd(rq(16'h1000, 1'b0, MOD_DEC));
      chk("rd word", 16'ha55a, rdResp.data);
      chk("rd ptr", 16'h0ffe, rdResp.ptrNext);
   endtask
   task automatic t_byte();
      wr(rq(16'h1001, 1'b1, MOD_NONE), 16'h3c00);
      rd(rq(16'h1000, 1'b0, MOD_NONE));
      chk("byte wr", 16'h3c5a, rdResp.data);
      rd(rq(16'h1001, 1'b1, MOD_INC), 16'h7788);
      chk("byte hi", 16'h003c, rdResp.data);
      chk("wreg", 16'h773c, rdResp.wregNew);
      chk("byte ptr", 16'h1002, rdResp.ptrNext);
      rd(rq(16'h1000, 1'b1, MOD_NONE));
      chk("byte lo", 16'h005a, rdResp.data);
   endtask
   task automatic t_misal();
      wr(rq(16'h1003, 1'b0, MOD_NONE), 16'hffff);
      chk("suppress", 1'b1, wrResp.suppressed);
      chk("trap wr", 2'h3, {addrErrReq, addrErrIsWrite});
      rd(rq(16'h1001, 1'b0, MOD_NONE));
      chk("misal rd", 16'h3c5a, rdResp.data);
      chk("trap rd", 2'h2, {addrErrReq, addrErrIsWrite});
      rd(rq(16'h1002, 1'b0, MOD_NONE));
      chk("no write", 16'h0000, rdResp.data);
      chk("trap off", 1'b0, addrErrReq);
   endtask
   task automatic t_unimpl();
      rd(rq(16'h1040, 1'b0, MOD_NONE));
      chk("outside", 16'h0000, rdResp.data);
      wr(rq(16'h1000, 1'b0, MOD_NONE, MODE_INDIRECT, 8'h01), 16'h1111);
      chk("wr xaddr", 24'h011000, wrResp.xAddr);
      rd(rq(16'h1000, 1'b0, MOD_NONE, MODE_INDIRECT, 8'h01));
      chk("page rd", 16'h0000, rdResp.data);
      chk("xaddr", 24'h011000, rdResp.xAddr);
      rd(rq(16'h1000, 1'b0, MOD_NONE));
      chk("page wr", 16'h3c5a, rdResp.data);
   endtask
   task automatic t_sfr();
      wr(rq(16'h0240, 1'b0, MOD_NONE), 16'h1234);
      chk("lanes", LANE_BOTH, sfrWrLanes);
      wr(rq(16'h0241, 1'b1, MOD_NONE), 16'hab00);
      chk("lane hi", LANE_HI, sfrWrLanes);
      chk("wr addr", 16'h0240, sfrWrAddr);
      rd(rq(16'h0240, 1'b0, MOD_NONE, MODE_DIRECT16));
      chk("sfr rd", 16'hab34, rdResp.data);
      rd(rq(16'h2241, 1'b1, MOD_NONE, MODE_NEAR13));
      chk("near", 16'h00ab, rdResp.data);
      rd(rq(16'h0250, 1'b0, MOD_NONE));
      chk("hole", 16'h0000, rdResp.data);
   endtask
   // read and write paths run in the same cycle
   task automatic t_dual();
      fork
         rd(rq(16'h1000, 1'b0, MOD_NONE));
         wr(rq(16'h1004, 1'b0, MOD_NONE), 16'hbeef);
      join
      chk("dual rd", 16'h3c5a, rdResp.data);
      rd(rq(16'h1004, 1'b0, MOD_NONE));
      chk("dual wr", 16'hbeef, rdResp.data);
   endtask
   task automatic t_ext(input extOp_t op, input logic [15:0] exp);
      @(negedge clk);
      extEn = 1'b1;
      extOp = op;
      extSrc = 16'h1285;
      @(negedge clk);
      extEn = 1'b0;
      chk("ext valid", op != EXT_NONE, extValid);
      chk("ext", exp, extResult);
   endtask
   // walk the whole 16-entry reversed sequence, wrapping at the end
   task automatic t_bitrev();
      for (int i = 0; i < 16; i++)
      begin
         rd(rq({11'h080, rev4(4'(i)), 1'b0}, 1'b0, MOD_BITREV));
         chk("bitrev", {11'h080, rev4(4'(i + 1)), 1'b0}, rdResp.ptrNext);
      end
   endtask
   task automatic end_of_test();
      if (bad_count == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(negedge clk);
      arst_n = 1'b1;
      t_word();
      t_byte();
      t_misal();
      t_unimpl();
      t_sfr();
      t_dual();
      t_ext(EXT_SIGN, 16'hff85);
      t_ext(EXT_ZERO, 16'h0085);
      t_ext(EXT_NONE, 16'h0085);
      t_bitrev();
      end_of_test();
   end
   // the tests need about a hundred cycles; this allows many times that
   initial
   begin
      #100000;
      bad_count++;
      end_of_test();
   end
endmodule
`default_nettype wire
